//--- verilog/vecirq_pkg.sv
`default_nettype none
package vecirq_pkg;
	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int unsigned VEC_W     = 8;
	localparam int unsigned STAT_W    = 8;
	localparam logic [7:0]  VEC_RESET = 8'h0F;   // uninitialised-vector value
	localparam int unsigned SYNC_LEN  = 2;       // pin synchroniser depth

	// ------------------------------------------------------------
	// acknowledge cycle states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		VECIRQ_IDLE,
		VECIRQ_DRIVE,
		VECIRQ_ACK
	} vecirq_state_e;
endpackage : vecirq_pkg
`default_nettype wire

//--- verilog/vecirq_top.sv
// Contract
// (RULE1) on acknowledge, drive a vector onto data
// (RULE2) both vectors reset to 0Fh
// (RULE3) acknowledge alone starts response, no select
// (RULE4) assert transfer acknowledge once vector drives
// (RULE5) acknowledge release ends transfer acknowledge
// (RULE6) open-drain active-low request line
// (RULE7) release request only when all causes cleared
// (RULE8) host loads vectors with 40h to FFh
// (RULE9) host holds acknowledge; address is vector times 4
// (RULE10) host reads status, clears causes
// (RULE11) first cause picks first vector, else second
// (RULE12) masked status is status AND mask
// (RULE13) vector output only in vectored modes
// (RULE14) idle: bus undriven, transfer acknowledge high
`timescale 1ns/1ns
`default_nettype none
module vecirq_top
#(
	parameter int unsigned VEC_W  = vecirq_pkg::VEC_W,
	parameter int unsigned STAT_W = vecirq_pkg::STAT_W
) (
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire logic              clk_en,
	input  wire logic              bus_mode_68,
	input  wire logic              vectored_submode,
	input  wire logic              irq_ack_in_n,
	input  wire logic [STAT_W-1:0] int_status_first,
	input  wire logic [STAT_W-1:0] int_status_second,
	input  wire logic [STAT_W-1:0] int_mask_first,
	input  wire logic [STAT_W-1:0] int_mask_second,
	input  wire logic              vec_wr_en,
	input  wire logic              vec_wr_sel,
	input  wire logic [VEC_W-1:0]  vec_wr_data,
	output logic [VEC_W-1:0]       data_out,
	output logic                   data_oe,
	output logic                   transfer_ack_n,
	output logic                   irq_out_n,
	output logic                   irq_out_oe,
	output logic [STAT_W-1:0]      masked_int_status_first,
	output logic [STAT_W-1:0]      masked_int_status_second,
	output logic [VEC_W-1:0]       vector_reg_first,
	output logic [VEC_W-1:0]       vector_reg_second
);
	// ------------------------------------------------------------
	// local sizes
	// ------------------------------------------------------------
	localparam int unsigned SYNC_LEN = vecirq_pkg::SYNC_LEN;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	// synchroniser chains, one per asynchronous pin
	logic [SYNC_LEN-1:0]       ack_sync_reg;
	logic [SYNC_LEN-1:0]       mode_sync_reg;

	// decoded conditions
	wire                       ack_active;
	wire                       vectored_mode;
	wire [STAT_W-1:0]          masked_first;
	wire [STAT_W-1:0]          masked_second;
	wire                       cause_first;
	wire                       cause_second;
	wire                       any_cause;
	wire [VEC_W-1:0]           chosen_vector;

	// vector write decode
	wire                       wr_first;
	wire                       wr_second;
	wire [VEC_W-1:0]           vector_first_next;
	wire [VEC_W-1:0]           vector_second_next;

	// acknowledge cycle control
	vecirq_pkg::vecirq_state_e state_reg;
	vecirq_pkg::vecirq_state_e state_next;
	wire                       in_idle;
	wire                       in_drive;
	wire                       in_ack;
	wire                       start_cycle;
	wire                       grant_ack;
	wire                       abort_cycle;
	wire                       finish_cycle;
	wire [VEC_W-1:0]           data_out_next;
	wire                       data_oe_next;
	wire                       transfer_ack_n_next;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// true when the state register holds the given state
	function automatic logic state_is(
		input vecirq_pkg::vecirq_state_e cur,
		input vecirq_pkg::vecirq_state_e want
	);
		state_is = (cur == want);
	endfunction : state_is

	// next state of the acknowledge cycle; the spare code falls back to idle
	function automatic vecirq_pkg::vecirq_state_e step_state(
		input vecirq_pkg::vecirq_state_e cur,
		input logic                      ack,
		input logic                      vmode
	);
		unique case (cur)
			vecirq_pkg::VECIRQ_IDLE: begin
				step_state = (ack && vmode) ? vecirq_pkg::VECIRQ_DRIVE : vecirq_pkg::VECIRQ_IDLE;
			end
			vecirq_pkg::VECIRQ_DRIVE: begin
				step_state = ack ? vecirq_pkg::VECIRQ_ACK : vecirq_pkg::VECIRQ_IDLE;
			end
			vecirq_pkg::VECIRQ_ACK: begin
				step_state = ack ? vecirq_pkg::VECIRQ_ACK : vecirq_pkg::VECIRQ_IDLE;
			end
			default: begin
				step_state = vecirq_pkg::VECIRQ_IDLE;
			end
		endcase
	endfunction : step_state

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// first stage only feeds the second; ack and mode pins are from another domain
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ack_sync_reg  <= '1;                  // idle high, so no false acknowledge after reset
			mode_sync_reg <= '0;
		end else if (clk_en) begin
			ack_sync_reg  <= {ack_sync_reg[0], irq_ack_in_n};
			mode_sync_reg <= {mode_sync_reg[0], bus_mode_68};
		end
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// chip select is deliberately not an input: acknowledge alone is enough
	assign ack_active    = ~ack_sync_reg[SYNC_LEN-1];                   // see (RULE3)
	assign vectored_mode = mode_sync_reg[SYNC_LEN-1] | vectored_submode; // see (RULE13)

	// masked-out conditions never reach the request line
	assign masked_first  = int_status_first & int_mask_first;           // see (RULE12)
	assign masked_second = int_status_second & int_mask_second;         // see (RULE12)
	assign cause_first   = |masked_first;
	assign cause_second  = |masked_second;
	assign any_cause     = cause_first | cause_second;

	// first group wins when both have a cause; host then services it first
	assign chosen_vector = cause_first ? vector_reg_first : vector_reg_second; // see (RULE11)

	// ------------------------------------------------------------
	// vector storage, plain read/write in non-vectored mode
	// ------------------------------------------------------------
	// a write during an acknowledge cycle leaves the latched bus value alone
	assign wr_first           = vec_wr_en & ~vec_wr_sel;
	assign wr_second          = vec_wr_en & vec_wr_sel;
	assign vector_first_next  = wr_first ? vec_wr_data : vector_reg_first;
	assign vector_second_next = wr_second ? vec_wr_data : vector_reg_second;

	// both vectors start at the uninitialised value
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			vector_reg_first  <= vecirq_pkg::VEC_RESET;   // see (RULE2)
			vector_reg_second <= vecirq_pkg::VEC_RESET;   // see (RULE2)
		end else if (clk_en) begin
			vector_reg_first  <= vector_first_next;
			vector_reg_second <= vector_second_next;
		end
	end

	// ------------------------------------------------------------
	// request line and masked status
	// ------------------------------------------------------------
	// pull low while any enabled cause stands; release only when all clear
	// the pin value is always low, the enable alone decides the line level
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			irq_out_n                <= 1'h0;
			irq_out_oe               <= 1'h0;
			masked_int_status_first  <= '0;
			masked_int_status_second <= '0;
		end else if (clk_en) begin
			irq_out_n                <= 1'h0;            // open drain: only ever pulls low, see (RULE6)
			irq_out_oe               <= any_cause;       // see (RULE7)
			masked_int_status_first  <= masked_first;    // see (RULE12)
			masked_int_status_second <= masked_second;   // see (RULE12)
		end
	end

	// ------------------------------------------------------------
	// acknowledge cycle decode
	// ------------------------------------------------------------
	// vector is placed one cycle before transfer acknowledge so data is settled
	assign in_idle      = state_is(state_reg, vecirq_pkg::VECIRQ_IDLE);
	assign in_drive     = state_is(state_reg, vecirq_pkg::VECIRQ_DRIVE);
	assign in_ack       = state_is(state_reg, vecirq_pkg::VECIRQ_ACK);
	assign start_cycle  = in_idle & ack_active & vectored_mode;      // see (RULE13)
	assign grant_ack    = in_drive & ack_active;
	assign abort_cycle  = in_drive & ~ack_active;
	assign finish_cycle = in_ack & ~ack_active;
	assign state_next   = step_state(state_reg, ack_active, vectored_mode);

	// the vector is frozen at the start so a late cause cannot change the bus
	assign data_out_next       = start_cycle ? chosen_vector : data_out;         // see (RULE1)
	assign data_oe_next        = start_cycle | (data_oe & ~(abort_cycle | finish_cycle)); // see (RULE1) (RULE14)
	// transfer acknowledge only after a full cycle with data standing
	assign transfer_ack_n_next = grant_ack ? 1'h0 :                             // see (RULE4)
	                             finish_cycle ? 1'h1 : transfer_ack_n;          // see (RULE5)

	// ------------------------------------------------------------
	// acknowledge cycle registers
	// ------------------------------------------------------------
	// outside a cycle the bus is released and transfer acknowledge stays high
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg      <= vecirq_pkg::VECIRQ_IDLE;
			data_out       <= '0;
			data_oe        <= 1'h0;                   // see (RULE14)
			transfer_ack_n <= 1'h1;                   // see (RULE14)
		end else if (clk_en) begin
			state_reg      <= state_next;
			data_out       <= data_out_next;
			data_oe        <= data_oe_next;
			transfer_ack_n <= transfer_ack_n_next;
		end
	end
endmodule : vecirq_top
`default_nettype wire

//--- tb/vecirq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------
// port checker, clk_en held high by the bench
// -------------------------------------------
module vecirq_monitor (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       irq_ack_in_n,
	input wire logic       data_oe,
	input wire logic       transfer_ack_n,
	input wire logic       irq_out_n,
	input wire logic       irq_out_oe,
	input wire logic [7:0] int_status_first,
	input wire logic [7:0] int_mask_first,
	input wire logic [7:0] int_status_second,
	input wire logic [7:0] int_mask_second,
	input wire logic [7:0] data_out,
	input wire logic [7:0] vector_reg_first,
	input wire logic [7:0] vector_reg_second,
	input wire logic [7:0] masked_int_status_first,
	input wire logic [7:0] masked_int_status_second
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_vec_default: assert property (disable iff (1'h0)
		!nrst |=> {vector_reg_first, vector_reg_second} == 16'h0F0F) else $error("reset vector");
	a_vec_pick: assert property ($rose(data_oe) |->
		data_out == (|masked_int_status_first ? vector_reg_first : vector_reg_second)) else $error("vector");
	a_ack_alone: assert property ($rose(data_oe) |->
		!irq_ack_in_n && !$past(irq_ack_in_n, 3)) else $error("no ack");
	a_tack_after: assert property ($rose(data_oe) |=> !transfer_ack_n) else $error("tack");
	a_tack_ends: assert property (irq_ack_in_n [*5] |->
		transfer_ack_n && !data_oe) else $error("no end");
	a_tack_drives: assert property (!transfer_ack_n |-> data_oe) else $error("idle tack");
	a_req_level: assert property (irq_out_n == 1'h0 &&
		irq_out_oe == |{masked_int_status_first, masked_int_status_second}) else $error("request");
	a_mask_and: assert property ($past(nrst) |->
		masked_int_status_first == ($past(int_status_first) & $past(int_mask_first))) else $error("mask");
	a_mask_second: assert property ($past(nrst) |->
		masked_int_status_second == ($past(int_status_second) & $past(int_mask_second))) else $error("mask two");
	c_first: cover property ($rose(data_oe) && |masked_int_status_first);
	c_second: cover property ($rose(data_oe) && !(|masked_int_status_first));
	c_done: cover property ($rose(transfer_ack_n));
endmodule : vecirq_monitor
bind vecirq_top vecirq_monitor u_vecirq_monitor (
	.ref_clk                  (ref_clk),
	.nrst                     (nrst),
	.irq_ack_in_n             (irq_ack_in_n),
	.data_oe                  (data_oe),
	.transfer_ack_n           (transfer_ack_n),
	.irq_out_n                (irq_out_n),
	.irq_out_oe               (irq_out_oe),
	.int_status_first         (int_status_first),
	.int_mask_first           (int_mask_first),
	.int_status_second        (int_status_second),
	.int_mask_second          (int_mask_second),
	.data_out                 (data_out),
	.vector_reg_first         (vector_reg_first),
	.vector_reg_second        (vector_reg_second),
	.masked_int_status_first  (masked_int_status_first),
	.masked_int_status_second (masked_int_status_second)
);
`default_nettype wire

//--- tb/vecirq_host.sv
`timescale 1ns/1ns
`default_nettype none
// ---------
// host side
// ---------
module vecirq_host (
	input wire logic       ref_clk,
	input wire logic       en,
	input wire logic       irq_line_n,
	input wire logic       transfer_ack_n,
	input wire logic [7:0] data_bus,
	output var logic       ack_n = 1'h1,
	output var logic [7:0] vec_seen = 8'h00,
	output var logic [7:0] acks = 8'h00,
	output var logic [9:0] isr_addr = 10'h000
);
	// ack held until the vector is taken, so a slow device is served too
	always begin
		@(posedge ref_clk iff (en && !irq_line_n));
		@(negedge ref_clk) ack_n = 1'h0;
		@(posedge ref_clk iff !transfer_ack_n) vec_seen = data_bus;
		isr_addr = {data_bus, 2'h0};
		@(negedge ref_clk) ack_n = 1'h1;
		@(posedge ref_clk iff transfer_ack_n) acks++;
	end
endmodule : vecirq_host
`default_nettype wire

//--- tb/test_vectored_irq_ack.sv
`timescale 1ns/1ns
`default_nettype none
// -----
// bench
// -----
module test_vectored_irq_ack;
	logic ref_clk = 0, nrst = 0, clk_en = 1, bus_mode_68 = 1, vectored_submode = 0;
	logic vec_wr_en = 0, vec_wr_sel = 0, en = 0;
	logic [7:0] int_status_first = '0, int_status_second = '0, int_mask_first = '0, int_mask_second = '0;
	logic [7:0] vec_wr_data = '0;
	wire logic [7:0] data_out, vector_reg_first, vector_reg_second, vs, acks;
	wire logic [7:0] masked_int_status_first, masked_int_status_second;
	wire logic data_oe, transfer_ack_n, irq_out_n, irq_out_oe, irq_ack_in_n;
	wire logic [9:0] addr;
	int bad_count = 0, n_tests = 0;
	vecirq_top u_vecirq_top (
		.ref_clk                  (ref_clk),
		.nrst                     (nrst),
		.clk_en                   (clk_en),
		.bus_mode_68              (bus_mode_68),
		.vectored_submode         (vectored_submode),
		.irq_ack_in_n             (irq_ack_in_n),
		.int_status_first         (int_status_first),
		.int_status_second        (int_status_second),
		.int_mask_first           (int_mask_first),
		.int_mask_second          (int_mask_second),
		.vec_wr_en                (vec_wr_en),
		.vec_wr_sel               (vec_wr_sel),
		.vec_wr_data              (vec_wr_data),
		.data_out                 (data_out),
		.data_oe                  (data_oe),
		.transfer_ack_n           (transfer_ack_n),
		.irq_out_n                (irq_out_n),
		.irq_out_oe               (irq_out_oe),
		.masked_int_status_first  (masked_int_status_first),
		.masked_int_status_second (masked_int_status_second),
		.vector_reg_first         (vector_reg_first),
		.vector_reg_second        (vector_reg_second)
	);
	// released request line is pulled high; an idle bus shows the inverse
	vecirq_host u_vecirq_host (
		.ref_clk        (ref_clk),
		.en             (en),
		.irq_line_n     (irq_out_oe ? irq_out_n : 1'h1),
		.transfer_ack_n (transfer_ack_n),
		.data_bus       (data_oe ? data_out : ~data_out),
		.ack_n          (irq_ack_in_n),
		.vec_seen       (vs),
		.acks           (acks),
		.isr_addr       (addr)
	);
	initial forever #4 ref_clk = ~ref_clk;
	task chk(input string s, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task wr(input logic s, input logic [7:0] d);
		@(negedge ref_clk) {vec_wr_en, vec_wr_sel, vec_wr_data} = {1'h1, s, d};
		@(negedge ref_clk) vec_wr_en = 0;
	endtask : wr
	task t_regs;
		chk("reset vectors", 16'h0F0F, {vector_reg_first, vector_reg_second});
		chk("idle bus", 16'h0001, {data_oe, transfer_ack_n});
		wr(0, 8'h40);
		wr(1, 8'hFF);
		chk("written vectors", 16'h40FF, {vector_reg_first, vector_reg_second});
		$display("t_regs done");
	endtask : t_regs
	// full acknowledge cycle, then clear causes; waits are bounded
	task serve(input string nm, input logic [7:0] sf, mf, ss, ms, e);
		logic [7:0] a;
		{int_status_first, int_mask_first, int_status_second, int_mask_second} = {sf, mf, ss, ms};
		a = acks;
		repeat (3) @(negedge ref_clk);
		chk("masked", {sf & mf, ss & ms}, {masked_int_status_first, masked_int_status_second});
		chk("request", 16'h0001, irq_out_oe);
		en = 1;
		for (int i = 0; i < 40 && acks == a; i++) @(negedge ref_clk);
		{en, int_status_first, int_status_second} = '0;
		chk("ack cycles", a + 8'h01, acks);
		chk("vector", e, vs);
		chk("isr address", e * 4, addr);
		repeat (3) @(negedge ref_clk);
		chk("released", 16'h0000, irq_out_oe);
		$display("%s done", nm);
	endtask : serve
	task t_first;
		bus_mode_68 = 1;
		vectored_submode = 0;
		serve("both", 8'h01, 8'h01, 8'h80, 8'h80, 8'h40);
	endtask : t_first
	task t_second;
		bus_mode_68 = 0;
		vectored_submode = 1;
		serve("masked", 8'h01, 8'h00, 8'h80, 8'h80, 8'hFF);
	endtask : t_second
	// non-vectored mode: acknowledge is ignored, vectors are plain storage; host is left waiting
	task t_plain;
		int seen;
		bus_mode_68 = 0;
		vectored_submode = 0;
		seen = 0;
		repeat (3) @(negedge ref_clk);
		{int_status_first, int_mask_first} = {8'h01, 8'h01};
		en = 1;
		repeat (20) begin
			@(negedge ref_clk);
			if (data_oe !== 1'h0 || transfer_ack_n !== 1'h1) seen++;
		end
		chk("plain mode bus", 16'h0000, seen[15:0]);
		wr(0, 8'h55);
		chk("plain storage", 16'h0055, vector_reg_first);
		$display("t_plain done");
	endtask : t_plain
	initial begin
		repeat (4) @(negedge ref_clk);
		nrst = 1;
		repeat (3) @(negedge ref_clk);
		t_regs;
		t_first;
		t_second;
		t_plain;
		complete_run;
	end
	// tests need about 70 cycles; allow 1000
	initial begin
		#8000;
		bad_count++;
		complete_run;
	end
endmodule : test_vectored_irq_ack
`default_nettype wire
